// *** inc/posc_pkg.sv ***
// constants for the power-on strap capture block
// assumes a single 100 MHz clock and an index/data i/o port pair reached by the host
// Overview of operation
// RULE1: sample low memory data straps when reset ends
// RULE2: index port 22h, data port 23h, index 4Ah
// RULE3: bits 7-6 set pci clock pll range
// RULE4: bit 5 selects async or sync memory clock
// RULE5: bit 4 is first pci divisor strap
// RULE6: cpu multiplier strap: 0 times one, 1 times two
// RULE7: board holds reserved straps at required levels; the board model passes bits 1-0 from user_md
// RULE8: bus select strap: 0 isa, 1 local bus
// RULE9: pll code 00 low range, 01 high, 1x reserved
// RULE10: pci clock is host clock over 4, 3 or 2
package posc_pkg;
  localparam logic [15:0] IDX_PORT = 16'h0022;
  localparam logic [15:0] DATA_PORT = 16'h0023;
  localparam logic [7:0] POWER_ON_STRAP_CONFIG_0_IDX = 8'h4A;
  localparam int PLL_MSB = 7;
  localparam int PLL_LSB = 6;
  localparam int SYNC_BIT = 5;
  localparam int DIV_A_BIT = 4;
  localparam logic [7:0] RSV_MASK = 8'h03;
  localparam logic [7:0] POWER_ON_STRAP_CONFIG_0_RST = 8'h00;
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    POSC_PLL_LOW = 2'b00,
    POSC_PLL_HIGH = 2'b01,
    POSC_PLL_RSV = 2'b10
  } posc_pll_t;
  typedef enum logic [1:0] {
    POSC_DIV4 = 2'b00,
    POSC_DIV3 = 2'b01,
    POSC_DIV2 = 2'b10
  } posc_div_t;
  typedef enum logic [1:0] {
    POSC_ST_SAMPLE = 2'b00,
    POSC_ST_LATCH = 2'b01,
    POSC_ST_RUN = 2'b10
  } posc_state_t;
endpackage

// *** rtl/posc_strap_capture.sv ***
// power-on strap capture: latches strap pins after reset and serves register 0
// assumes the board drives the straps during reset and an i/o bus cycle strobe on clk_sys
`timescale 1ns/1ps
`default_nettype none
module posc_strap_capture (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] md_low_pins,
  input wire logic pci_div_strap_b,
  input wire logic cpu_multiplier_strap,
  input wire logic bus_select_strap,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic [1:0] pci_pll_range,
  output logic pll_range_reserved,
  output logic clock_sync_mode,
  output logic [1:0] pci_div_sel,
  output logic cpu_x2_mode,
  output logic local_bus_sel,
  output logic straps_valid
);
  // straps are board levels, so they go through two flops first
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic [7:0] power_on_strap_config_0_q;
  logic div_b_q;
  logic cpu_x2_q;
  logic local_bus_q;
  logic [7:0] index_q;
  posc_pkg::posc_state_t state_q;
  posc_pkg::posc_state_t state_d;

  // no reset here on purpose: the flops follow the pins while reset is low,
  // otherwise the capture edge would latch the cleared synchroniser, not the straps
  always_ff @(posedge clk_sys) begin
    pin_s1_q <= {bus_select_strap, cpu_multiplier_strap, pci_div_strap_b, md_low_pins};
    pin_s2_q <= pin_s1_q;
  end

  // two cycles after release the synchroniser holds the real strap levels
  always_comb begin
    case (state_q)
      posc_pkg::POSC_ST_SAMPLE: state_d = posc_pkg::POSC_ST_LATCH;
      posc_pkg::POSC_ST_LATCH: state_d = posc_pkg::POSC_ST_RUN;
      posc_pkg::POSC_ST_RUN: state_d = posc_pkg::POSC_ST_RUN;
      default: state_d = posc_pkg::POSC_ST_SAMPLE;
    endcase
  end

  // full 16-bit compare, so aliases of the two ports higher up are not taken
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    port_hit = (addr == port);
  endfunction

  wire capture = (state_q == posc_pkg::POSC_ST_LATCH);
  wire at_idx = port_hit(io_addr, posc_pkg::IDX_PORT);
  wire at_data = port_hit(io_addr, posc_pkg::DATA_PORT);
  wire idx_wr = io_wr && at_idx;
  wire sel_power_on_strap_config_0 = (index_q == posc_pkg::POWER_ON_STRAP_CONFIG_0_IDX);
  wire data_wr = io_wr && at_data && sel_power_on_strap_config_0;
  wire [7:0] power_on_strap_config_0_wmask = ~posc_pkg::RSV_MASK;
  wire [7:0] rd_mux = at_idx ? index_q : (at_data && sel_power_on_strap_config_0) ? power_on_strap_config_0_q : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= posc_pkg::POSC_ST_SAMPLE;
      power_on_strap_config_0_q <= posc_pkg::POWER_ON_STRAP_CONFIG_0_RST;
      div_b_q <= 1'b0;
      cpu_x2_q <= 1'b0;
      local_bus_q <= 1'b0;
      index_q <= posc_pkg::IDX_RST;
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      state_q <= state_d;
      if (capture) begin
        power_on_strap_config_0_q <= pin_s2_q[7:0] & power_on_strap_config_0_wmask; // [RULE1]
        div_b_q <= pin_s2_q[8];
        cpu_x2_q <= pin_s2_q[9]; // [RULE6]
        local_bus_q <= pin_s2_q[10]; // [RULE8]
      end else if (data_wr) begin
        // software may override the sampled setting; reserved bits stay zero
        power_on_strap_config_0_q <= io_wdata & power_on_strap_config_0_wmask; // [RULE2]
      end
      if (idx_wr) begin
        index_q <= io_wdata; // [RULE2]
      end
      io_rvalid <= io_rd;
      io_rdata <= io_rd ? rd_mux : 8'h00; // [RULE2]
    end
  end

  // decoded outputs, registered so every output leaves a flop
  wire [1:0] pll_code = power_on_strap_config_0_q[posc_pkg::PLL_MSB:posc_pkg::PLL_LSB];
  wire pll_rsv = power_on_strap_config_0_q[posc_pkg::PLL_MSB]; // [RULE9]
  wire div_a = power_on_strap_config_0_q[posc_pkg::DIV_A_BIT];
  wire [1:0] div_code = !div_a ? posc_pkg::POSC_DIV4 :
                        (!div_b_q ? posc_pkg::POSC_DIV3 : posc_pkg::POSC_DIV2);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pci_pll_range <= 2'h0;
      pll_range_reserved <= 1'b0;
      clock_sync_mode <= 1'b0;
      pci_div_sel <= 2'h0;
      cpu_x2_mode <= 1'b0;
      local_bus_sel <= 1'b0;
      straps_valid <= 1'b0;
    end else begin
      pci_pll_range <= pll_code; // [RULE3]
      pll_range_reserved <= pll_rsv; // [RULE9]
      clock_sync_mode <= power_on_strap_config_0_q[posc_pkg::SYNC_BIT]; // [RULE4]
      pci_div_sel <= div_code; // [RULE5] [RULE10]
      cpu_x2_mode <= cpu_x2_q; // [RULE6]
      local_bus_sel <= local_bus_q; // [RULE8]
      straps_valid <= (state_q == posc_pkg::POSC_ST_RUN);
    end
  end

  property p_capture;
    @(posedge clk_sys) disable iff (!arst_n)
      capture |=> power_on_strap_config_0_q == ($past(pin_s2_q[7:0]) & ~posc_pkg::RSV_MASK);
  endproperty
  a_capture: assert property (p_capture) else $error("power_on_strap_config_0 not loaded from pins"); // [RULE1]

  property p_index;
    @(posedge clk_sys) disable iff (!arst_n)
      io_rd && io_addr == posc_pkg::DATA_PORT && index_q == posc_pkg::POWER_ON_STRAP_CONFIG_0_IDX
        |=> io_rvalid && io_rdata == $past(power_on_strap_config_0_q);
  endproperty
  a_index: assert property (p_index) else $error("data port read wrong"); // [RULE2]

  property p_pll;
    @(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> pci_pll_range == $past(power_on_strap_config_0_q[posc_pkg::PLL_MSB:posc_pkg::PLL_LSB]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll range mismatch"); // [RULE3]

  property p_sync;
    @(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> clock_sync_mode == $past(power_on_strap_config_0_q[posc_pkg::SYNC_BIT]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync mode mismatch"); // [RULE4]

  property p_div4;
    @(posedge clk_sys) disable iff (!arst_n)
      !power_on_strap_config_0_q[posc_pkg::DIV_A_BIT] |=> pci_div_sel == posc_pkg::POSC_DIV4;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four expected"); // [RULE5]

  property p_div;
    @(posedge clk_sys) disable iff (!arst_n)
      power_on_strap_config_0_q[posc_pkg::DIV_A_BIT] |=> pci_div_sel == ($past(div_b_q) ? posc_pkg::POSC_DIV2 : posc_pkg::POSC_DIV3);
  endproperty
  a_div: assert property (p_div) else $error("divide three or two wrong"); // [RULE10]

  property p_cpu;
    @(posedge clk_sys) disable iff (!arst_n) capture |-> ##2 cpu_x2_mode == $past(pin_s2_q[9], 2);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu multiplier not captured"); // [RULE6]

  property p_bus;
    @(posedge clk_sys) disable iff (!arst_n) capture |-> ##2 local_bus_sel == $past(pin_s2_q[10], 2);
  endproperty
  a_bus: assert property (p_bus) else $error("bus select not captured"); // [RULE8]

  property p_rsv;
    @(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> pll_range_reserved == $past(power_on_strap_config_0_q[posc_pkg::PLL_MSB]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved pll code flag wrong"); // [RULE9]

  property p_data_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      data_wr && !capture |=> power_on_strap_config_0_q == ($past(io_wdata) & ~posc_pkg::RSV_MASK);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data port write not applied"); // [RULE2]

  // a data write with another index selected must leave the straps alone
  property p_wr_refused;
    @(posedge clk_sys) disable iff (!arst_n)
      io_wr && io_addr == posc_pkg::DATA_PORT && index_q != posc_pkg::POWER_ON_STRAP_CONFIG_0_IDX && !capture |=> $stable(power_on_strap_config_0_q);
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write with wrong index changed power_on_strap_config_0"); // [RULE2]

  property p_idx_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      io_wr && io_addr == posc_pkg::IDX_PORT |=> index_q == $past(io_wdata);
  endproperty
  a_idx_wr: assert property (p_idx_wr) else $error("index write not taken"); // [RULE2]

  property p_idx_rd;
    @(posedge clk_sys) disable iff (!arst_n)
      io_rd && io_addr == posc_pkg::IDX_PORT |=> io_rvalid && io_rdata == $past(index_q);
  endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index read wrong"); // [RULE2]

  property p_other_rd;
    @(posedge clk_sys) disable iff (!arst_n)
      io_rd && io_addr != posc_pkg::IDX_PORT && io_addr != posc_pkg::DATA_PORT |=> io_rvalid && io_rdata == 8'h00;
  endproperty
  a_other_rd: assert property (p_other_rd) else $error("foreign port read not zero"); // [RULE2]

  property p_idle_rd;
    @(posedge clk_sys) disable iff (!arst_n) !io_rd |=> !io_rvalid && io_rdata == 8'h00;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside a read"); // [RULE2]

  property p_valid;
    @(posedge clk_sys) disable iff (!arst_n) capture |-> ##2 straps_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("straps valid late"); // [RULE1]

  property p_not_valid;
    @(posedge clk_sys) disable iff (!arst_n) state_q != posc_pkg::POSC_ST_RUN |=> !straps_valid;
  endproperty
  a_not_valid: assert property (p_not_valid) else $error("straps valid before capture"); // [RULE1]

  // capture-only straps must not move between resets
  property p_x2_hold;
    @(posedge clk_sys) disable iff (!arst_n) straps_valid && $past(straps_valid) |-> $stable(cpu_x2_mode);
  endproperty
  a_x2_hold: assert property (p_x2_hold) else $error("cpu multiplier moved after capture"); // [RULE6]

  property p_bus_hold;
    @(posedge clk_sys) disable iff (!arst_n) straps_valid && $past(straps_valid) |-> $stable(local_bus_sel);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus select moved after capture"); // [RULE8]

  c_capture: cover property (@(posedge clk_sys) disable iff (!arst_n) capture ##2 straps_valid);
  c_write: cover property (@(posedge clk_sys) disable iff (!arst_n) data_wr);
  c_read: cover property (@(posedge clk_sys) disable iff (!arst_n) io_rvalid && sel_power_on_strap_config_0);
  c_rsv: cover property (@(posedge clk_sys) disable iff (!arst_n) pll_range_reserved && straps_valid);
  c_div3: cover property (@(posedge clk_sys) disable iff (!arst_n)
    pci_div_sel == posc_pkg::POSC_DIV3 && straps_valid);
endmodule
`default_nettype wire

// *** verif/posc_strap_board.sv ***
// board side of the straps: pull resistors plus user-defined levels
// assumes the bench sets the user levels before it releases reset
`timescale 1ns/1ps
`default_nettype none
module posc_strap_board (
  input wire logic [7:0] user_md,
  input wire logic user_div_b,
  input wire logic user_x2,
  input wire logic user_bus,
  output logic [7:0] md_low_pins,
  output logic pci_div_strap_b,
  output logic cpu_multiplier_strap,
  output logic bus_select_strap
);
  // top strap is the pll range msb and sits on a pull-down whatever the user asks
  assign md_low_pins = {1'h0, user_md[6:0]};
  assign pci_div_strap_b = user_div_b;
  assign cpu_multiplier_strap = user_x2;
  assign bus_select_strap = user_bus;
endmodule
`default_nettype wire

// *** verif/power_on_strap_capture_tb.sv ***
// bench for the strap capture block: two resets, index/data port traffic
// assumes straps stay steady from reset entry until well after release
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module power_on_strap_capture_tb;
  logic clk_sys, arst_n, io_wr, io_rd, io_rvalid, pll_rsv, sync, x2m, lbs, sv, sb, sm, ss, ub, ux, us;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, md, um;
  logic [1:0] pll, div;
  int n_fail = 0;
  int total_checks = 0;
  posc_strap_board board (.user_md(um), .user_div_b(ub), .user_x2(ux), .user_bus(us), .md_low_pins(md),
    .pci_div_strap_b(sb), .cpu_multiplier_strap(sm), .bus_select_strap(ss));
  posc_strap_capture uut (.clk_sys(clk_sys), .arst_n(arst_n), .md_low_pins(md), .pci_div_strap_b(sb),
    .cpu_multiplier_strap(sm), .bus_select_strap(ss), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .pci_pll_range(pll),
    .pll_range_reserved(pll_rsv), .clock_sync_mode(sync), .pci_div_sel(div), .cpu_x2_mode(x2m),
    .local_bus_sel(lbs), .straps_valid(sv));
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_wr = 1'h1;
    io_addr = a;
    io_wdata = d;
    @(negedge clk_sys);
    io_wr = 1'h0;
  endtask
  // answer is registered and stands one cycle: look at it in the cycle after the request edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    io_rd = 1'h1;
    io_addr = a;
    @(negedge clk_sys);
    `CHK("rvalid", 1'h1, io_rvalid)
    `CHK("rdata", e, io_rdata)
    io_rd = 1'h0;
  endtask
  task automatic outs(input logic [1:0] p, input logic r, s, input logic [1:0] d, input logic x, l);
    `CHK("pll", p, pll)
    `CHK("pll_rsv", r, pll_rsv)
    `CHK("sync", s, sync)
    `CHK("div", d, div)
    `CHK("x2", x, x2m)
    `CHK("local_bus", l, lbs)
  endtask
  task automatic rst(input logic [7:0] m, input logic b, x, s);
    @(negedge clk_sys);
    arst_n = 1'h0;
    um = m;
    ub = b;
    ux = x;
    us = s;
    repeat (16) @(negedge clk_sys);
    `CHK("valid_in_reset", 1'h0, sv)
    arst_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    `CHK("valid", 1'h1, sv)
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // whole run is about 70 cycles; this is about seventy times that
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
  initial begin
    arst_n = 1'h0;
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    rst(8'hFF, 1'h1, 1'h1, 1'h0);
    outs(2'h1, 1'h0, 1'h1, 2'h2, 1'h1, 1'h0);
    wr(posc_pkg::IDX_PORT, posc_pkg::POWER_ON_STRAP_CONFIG_0_IDX);
    rd(16'h0022, 8'h4A);
    rd(16'h0023, 8'h7C);
    wr(16'h0023, 8'h83);
    repeat (2) @(negedge clk_sys);
    outs(2'h2, 1'h1, 1'h0, 2'h0, 1'h1, 1'h0);
    rd(16'h0023, 8'h80);
    wr(16'h0022, 8'h4B);
    wr(16'h0023, 8'h44);
    rd(16'h0023, 8'h00);
    rd(16'h0024, 8'h00);
    wr(16'h0022, 8'h4A);
    rd(16'h0023, 8'h80);
    rst(8'h94, 1'h0, 1'h0, 1'h1);
    outs(2'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h1);
    wr(16'h0022, 8'h4A);
    rd(16'h0023, 8'h14);
    summarize();
  end
endmodule
`default_nettype wire
